// *** verilog/fcd_dma_ctrl.sv ***
// Four-channel DMA controller with AXI4-Lite register access.
`timescale 1ns/1ps
`default_nettype none
module fcd_dma_ctrl #(
   parameter int NUM_CH = fcd_pkg::NUM_CH,
   parameter int NUM_PERI = 8,
   parameter int CNT_W = fcd_pkg::CNT_W
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [fcd_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [fcd_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NUM_CH-1:0] xfer_request_pin_n,
   output logic [NUM_CH-1:0] xfer_acknowledge_pin_n,
   output logic [NUM_CH-1:0] terminal_count_n,
   output logic [NUM_CH-1:0] transfer_end_irq,
   input wire logic [NUM_PERI-1:0] periph_irq,
   input wire logic bus_hold,
   input wire logic refresh_active,
   input wire logic nmi_in,
   output logic [31:0] xfer_src_addr,
   output logic [31:0] xfer_dst_addr,
   output logic xfer_strobe,
   output logic ext_bus_used
);
   localparam int TW = fcd_pkg::TMR_W;

   generate
      if (NUM_CH < 1 || NUM_CH > 4 || NUM_PERI < 1 || NUM_PERI > 8 ||
          CNT_W < 2 || CNT_W > 32) begin
         $error("Unsupported channel, peripheral or count width parameter.");
      end
   endgenerate

   // Pin synchronisers: three stages, a change counts once stages two and three agree.
   logic [NUM_CH:0] sync1_reg, sync2_reg, sync3_reg, pin_lvl_reg;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
         sync3_reg <= '1;
         pin_lvl_reg <= '1;
      end else begin
         sync1_reg <= {~nmi_in, xfer_request_pin_n};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_lvl_reg <= (sync2_reg & sync3_reg) | (pin_lvl_reg & (sync2_reg | sync3_reg));
      end
   end
   logic [NUM_CH-1:0] ext_req;
   logic nmi_lvl, nmi_prev_reg, nmi_event;
   assign ext_req = ~pin_lvl_reg[NUM_CH-1:0];
   assign nmi_lvl = ~pin_lvl_reg[NUM_CH];
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         nmi_prev_reg <= 1'b0;
      end else begin
         nmi_prev_reg <= nmi_lvl;
      end
   end
   assign nmi_event = nmi_lvl & ~nmi_prev_reg;

   // Per-channel state, then the global bus cycle type and NMI hold registers.
   logic [NUM_CH-1:0] en_reg, stg_reg, tc_reg, pend_reg, started_reg, half_reg, ack_reg;
   logic [NUM_CH-1:0] tc_pulse_reg;
   logic [1:0] mode_reg [NUM_CH];
   logic [1:0] sobj_reg [NUM_CH];
   logic [1:0] dobj_reg [NUM_CH];
   logic [7:0] trig_reg [NUM_CH];
   logic [31:0] stg_src_reg [NUM_CH];
   logic [31:0] stg_dst_reg [NUM_CH];
   logic [CNT_W-1:0] stg_cnt_reg [NUM_CH];
   logic [31:0] act_src_reg [NUM_CH];
   logic [31:0] act_dst_reg [NUM_CH];
   logic [CNT_W-1:0] act_cnt_reg [NUM_CH];
   logic [7:0] bct_reg;
   logic nmi_hold_reg;

   fcd_pkg::fcd_state_t state_reg;
   logic [1:0] cur_reg;
   logic [TW-1:0] tmr_reg;
   logic ext_path_reg;

   // Register bus: write address and data are captured independently.
   logic aw_have_reg, w_have_reg;
   logic [fcd_pkg::AXI_AW-1:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_fire;
   assign s_axi_awready = ~aw_have_reg;
   assign s_axi_wready = ~w_have_reg;
   assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;

   function automatic logic [31:0] rd_mux(input logic [fcd_pkg::AXI_AW-1:0] a, output logic ok);
      logic [1:0] c;
      logic [31:0] v;
      c = a[fcd_pkg::CH_SEL_LSB +: 2];
      v = '0;
      ok = 1'b1;
      if (a == fcd_pkg::OFF_BCT) begin
         v[7:0] = bct_reg;
      end else if (a == fcd_pkg::OFF_STAT) begin
         v = {26'h0, ext_bus_used, (state_reg != fcd_pkg::FCD_IDLE), nmi_hold_reg, 1'b0, cur_reg};
      end else if (a[fcd_pkg::GLOBAL_BIT] || 32'(c) >= NUM_CH) begin
         ok = 1'b0;
      end else begin
         unique case (a[4:0])
            fcd_pkg::OFF_CTRL: begin
               v[fcd_pkg::CTL_EN] = en_reg[c];
               v[fcd_pkg::CTL_STG] = stg_reg[c];
               v[fcd_pkg::CTL_TC] = tc_reg[c];
               v[fcd_pkg::CTL_MODE_LSB +: 2] = mode_reg[c];
               v[fcd_pkg::CTL_HALF] = half_reg[c];
               v[fcd_pkg::CTL_SOBJ_LSB +: 2] = sobj_reg[c];
               v[fcd_pkg::CTL_DOBJ_LSB +: 2] = dobj_reg[c];
            end
            fcd_pkg::OFF_TRIG: v[7:0] = trig_reg[c];
            fcd_pkg::OFF_SRC: v = stg_src_reg[c];
            fcd_pkg::OFF_DST: v = stg_dst_reg[c];
            fcd_pkg::OFF_CNT: v[CNT_W-1:0] = stg_cnt_reg[c];
            fcd_pkg::OFF_ACNT: v[CNT_W-1:0] = act_cnt_reg[c];
            default: ok = 1'b0;
         endcase
      end
      return v;
   endfunction

   logic [31:0] wr_old, wr_val, rd_val;
   logic wr_ok, rd_ok;
   always_comb begin
      wr_old = rd_mux(aw_addr_reg, wr_ok);
      for (int b = 0; b < 4; b++) begin
         wr_val[8*b +: 8] = w_strb_reg[b] ? w_data_reg[8*b +: 8] : wr_old[8*b +: 8];
      end
      rd_val = rd_mux(s_axi_araddr, rd_ok);
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= fcd_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_have_reg) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_reg) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? fcd_pkg::RESP_OKAY : fcd_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= fcd_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? fcd_pkg::RESP_OKAY : fcd_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   logic bct_wr;
   assign bct_wr = wr_fire && aw_addr_reg == fcd_pkg::OFF_BCT;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bct_reg <= '0;
      end else if (bct_wr) begin
         bct_reg <= wr_val[7:0];
      end
   end

   // Engine status shared with the channel slices.
   logic cyc_done, last_cyc, nmi_apply, suspend;
   logic [NUM_CH-1:0] elig, init_wr;
   logic [1:0] win;
   assign suspend = bus_hold | refresh_active;
   assign cyc_done = state_reg == fcd_pkg::FCD_XFER && !suspend && tmr_reg == '0;
   assign last_cyc = act_cnt_reg[cur_reg] == CNT_W'(1);
   assign nmi_apply = nmi_hold_reg && state_reg == fcd_pkg::FCD_IDLE;

   genvar i;
   generate
      for (i = 0; i < NUM_CH; i++) begin : g_ch
         logic sel, ctl_wr, mine_done, end_now, load, src_trig, set_pend;
         logic [1:0] inc;
         assign sel = wr_fire && !aw_addr_reg[fcd_pkg::GLOBAL_BIT] &&
                      32'(aw_addr_reg[fcd_pkg::CH_SEL_LSB +: 2]) == i;
         assign ctl_wr = sel && aw_addr_reg[4:0] == fcd_pkg::OFF_CTRL;
         assign init_wr[i] = ctl_wr && w_strb_reg[0] && w_data_reg[fcd_pkg::CTL_INIT];
         assign mine_done = cyc_done && 32'(cur_reg) == i;
         assign end_now = state_reg == fcd_pkg::FCD_END && 32'(cur_reg) == i;
         assign load = end_now || init_wr[i] ||
                       (ctl_wr && wr_val[fcd_pkg::CTL_EN] && !en_reg[i] && !started_reg[i]);
         assign src_trig = trig_reg[i][fcd_pkg::TRIG_ON] &&
                           periph_irq[trig_reg[i][fcd_pkg::TRIG_SEL_W-1:0]];
         assign set_pend = en_reg[i] && !tc_reg[i] &&
                           ((ext_req[i] && !ack_reg[i]) || stg_reg[i] || src_trig);
         assign inc = half_reg[i] ? 2'h2 : 2'h1;
         assign elig[i] = pend_reg[i] & en_reg[i] & ~tc_reg[i];

         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               en_reg[i] <= 1'b0;
               stg_reg[i] <= 1'b0;
               tc_reg[i] <= 1'b0;
               mode_reg[i] <= fcd_pkg::MODE_SINGLE;
               half_reg[i] <= 1'b0;
               sobj_reg[i] <= fcd_pkg::OBJ_RAM;
               dobj_reg[i] <= fcd_pkg::OBJ_RAM;
            end else begin
               if (ctl_wr) begin
                  en_reg[i] <= wr_val[fcd_pkg::CTL_EN] && !init_wr[i];
                  mode_reg[i] <= wr_val[fcd_pkg::CTL_MODE_LSB +: 2];
                  half_reg[i] <= wr_val[fcd_pkg::CTL_HALF];
                  sobj_reg[i] <= wr_val[fcd_pkg::CTL_SOBJ_LSB +: 2];
                  dobj_reg[i] <= wr_val[fcd_pkg::CTL_DOBJ_LSB +: 2];
               end else if (end_now || nmi_apply) begin
                  en_reg[i] <= 1'b0;
               end
               if (init_wr[i]) begin
                  stg_reg[i] <= 1'b0;
               end else if (ctl_wr && wr_val[fcd_pkg::CTL_STG]) begin
                  stg_reg[i] <= 1'b1;
               end else if (en_reg[i] && !tc_reg[i]) begin
                  stg_reg[i] <= 1'b0;
               end
               if (end_now) begin
                  tc_reg[i] <= 1'b1;
               end else if (init_wr[i] ||
                            (ctl_wr && w_strb_reg[0] && w_data_reg[fcd_pkg::CTL_TC])) begin
                  tc_reg[i] <= 1'b0;
               end
            end
         end

         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               pend_reg[i] <= 1'b0;
            end else if (init_wr[i] || end_now) begin
               pend_reg[i] <= 1'b0;
            end else if (set_pend) begin
               pend_reg[i] <= 1'b1;
            end else if ((mine_done && mode_reg[i] != fcd_pkg::MODE_STEP &&
                          mode_reg[i] != fcd_pkg::MODE_BLOCK) ||
                         (nmi_apply && mode_reg[i] != fcd_pkg::MODE_STEP &&
                          mode_reg[i] != fcd_pkg::MODE_BLOCK)) begin
               pend_reg[i] <= 1'b0;
            end
         end

         // Staged copies take every write; active copies only follow at the load points.
         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               trig_reg[i] <= '0;
               stg_src_reg[i] <= '0;
               stg_dst_reg[i] <= '0;
               stg_cnt_reg[i] <= '0;
            end else if (sel) begin
               if (aw_addr_reg[4:0] == fcd_pkg::OFF_TRIG) trig_reg[i] <= wr_val[7:0];
               if (aw_addr_reg[4:0] == fcd_pkg::OFF_SRC) stg_src_reg[i] <= wr_val;
               if (aw_addr_reg[4:0] == fcd_pkg::OFF_DST) stg_dst_reg[i] <= wr_val;
               if (aw_addr_reg[4:0] == fcd_pkg::OFF_CNT) stg_cnt_reg[i] <= wr_val[CNT_W-1:0];
            end
         end

         always_ff @(posedge core_clk or negedge arst_n) begin
            if (!arst_n) begin
               act_src_reg[i] <= '0;
               act_dst_reg[i] <= '0;
               act_cnt_reg[i] <= '0;
               started_reg[i] <= 1'b0;
            end else if (load) begin
               act_src_reg[i] <= stg_src_reg[i];
               act_dst_reg[i] <= stg_dst_reg[i];
               act_cnt_reg[i] <= stg_cnt_reg[i];
               started_reg[i] <= 1'b0;
            end else if (mine_done) begin
               act_src_reg[i] <= {act_src_reg[i][31:1], act_src_reg[i][0] & ~half_reg[i]} +
                                 32'(inc);
               act_dst_reg[i] <= {act_dst_reg[i][31:1], act_dst_reg[i][0] & ~half_reg[i]} +
                                 32'(inc);
               act_cnt_reg[i] <= act_cnt_reg[i] - CNT_W'(1);
               started_reg[i] <= 1'b1;
            end
         end
      end
   endgenerate

   // Lowest index wins among eligible channels.
   always_comb begin
      win = '0;
      for (int c = NUM_CH - 1; c >= 0; c--) begin
         if (elig[c]) win = 2'(c);
      end
   end

   function automatic logic [TW-1:0] obj_clk(input logic [1:0] obj, input logic [7:0] bus_cycle_type_reg);
      logic [TW-1:0] r;
      unique case (obj)
         fcd_pkg::OBJ_RAM: r = fcd_pkg::RAM_CLK;
         fcd_pkg::OBJ_PERI: r = fcd_pkg::PERI_CLK;
         fcd_pkg::OBJ_EXT_IO: r = fcd_pkg::EXT_BASE_CLK +
                                  TW'(bus_cycle_type_reg[fcd_pkg::BCT_IO_LSB +: fcd_pkg::BCT_W]);
         fcd_pkg::OBJ_EXT_MEM: r = fcd_pkg::EXT_BASE_CLK +
                                   TW'(bus_cycle_type_reg[fcd_pkg::BCT_MEM_LSB +: fcd_pkg::BCT_W]);
      endcase
      return r;
   endfunction

   logic [TW-1:0] cyc_len;
   logic cur_ext;
   assign cyc_len = obj_clk(sobj_reg[cur_reg], bct_reg) + obj_clk(dobj_reg[cur_reg], bct_reg) -
                    TW'(1);
   assign cur_ext = sobj_reg[cur_reg][1] | dobj_reg[cur_reg][1];

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         nmi_hold_reg <= 1'b0;
      end else if (nmi_event && state_reg != fcd_pkg::FCD_IDLE) begin
         nmi_hold_reg <= 1'b1;
      end else if (nmi_apply || (nmi_event && state_reg == fcd_pkg::FCD_IDLE)) begin
         nmi_hold_reg <= nmi_event && state_reg == fcd_pkg::FCD_IDLE;
      end
   end

   // Bus engine. The abort on initialize may cut a cycle short; that is the point of it.
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= fcd_pkg::FCD_IDLE;
         cur_reg <= '0;
         tmr_reg <= '0;
         ext_path_reg <= 1'b0;
         ack_reg <= '0;
         tc_pulse_reg <= '0;
         xfer_strobe <= 1'b0;
         ext_bus_used <= 1'b0;
         xfer_src_addr <= '0;
         xfer_dst_addr <= '0;
      end else begin
         tc_pulse_reg <= '0;
         xfer_strobe <= 1'b0;
         if (state_reg != fcd_pkg::FCD_IDLE && init_wr[cur_reg]) begin
            state_reg <= fcd_pkg::FCD_IDLE;
            ack_reg <= '0;
            ext_bus_used <= 1'b0;
         end else begin
            unique case (state_reg)
               fcd_pkg::FCD_IDLE: begin
                  if (|elig && !nmi_hold_reg) begin
                     cur_reg <= win;
                     ext_path_reg <= ext_req[win];
                     tmr_reg <= ext_req[win] ? fcd_pkg::ACK_LEAD_CLK - TW'(1) : '0;
                     state_reg <= fcd_pkg::FCD_START;
                  end
               end
               fcd_pkg::FCD_START: begin
                  if (tmr_reg != '0) begin
                     tmr_reg <= tmr_reg - TW'(1);
                  end else begin
                     ack_reg[cur_reg] <= ext_path_reg;
                     tmr_reg <= cyc_len;
                     ext_bus_used <= cur_ext;
                     xfer_src_addr <= {act_src_reg[cur_reg][31:1],
                                       act_src_reg[cur_reg][0] & ~half_reg[cur_reg]};
                     xfer_dst_addr <= {act_dst_reg[cur_reg][31:1],
                                       act_dst_reg[cur_reg][0] & ~half_reg[cur_reg]};
                     state_reg <= fcd_pkg::FCD_XFER;
                  end
               end
               fcd_pkg::FCD_XFER: begin
                  if (!suspend) begin
                     if (tmr_reg != '0) begin
                        tmr_reg <= tmr_reg - TW'(1);
                     end else begin
                        xfer_strobe <= 1'b1;
                        if (last_cyc) begin
                           ack_reg <= '0;
                           ext_bus_used <= 1'b0;
                           state_reg <= fcd_pkg::FCD_END;
                        end else if (mode_reg[cur_reg] == fcd_pkg::MODE_BLOCK &&
                                     !nmi_hold_reg) begin
                           tmr_reg <= cyc_len;
                           xfer_src_addr <= xfer_src_addr + (half_reg[cur_reg] ? 32'h2 : 32'h1);
                           xfer_dst_addr <= xfer_dst_addr + (half_reg[cur_reg] ? 32'h2 : 32'h1);
                        end else begin
                           ack_reg <= '0;
                           ext_bus_used <= 1'b0;
                           state_reg <= fcd_pkg::FCD_IDLE;
                        end
                     end
                  end
               end
               fcd_pkg::FCD_END: begin
                  tc_pulse_reg[cur_reg] <= 1'b1;
                  state_reg <= fcd_pkg::FCD_IDLE;
               end
            endcase
         end
      end
   end

   assign xfer_acknowledge_pin_n = ~ack_reg;
   assign terminal_count_n = ~tc_pulse_reg;
   assign transfer_end_irq = tc_reg;
endmodule
`default_nettype wire

// *** verilog/fcd_pkg.sv ***
// Shared constants for the four-channel DMA controller.
package fcd_pkg;
   localparam int NUM_CH = 4;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int CNT_W = 16;
   localparam int AXI_AW = 8;
   localparam int TMR_W = 6;

   // Register map, byte addresses.
   localparam logic [AXI_AW-1:0] CH_STRIDE = 8'h20;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_TRIG = 5'h04;
   localparam logic [4:0] OFF_SRC = 5'h08;
   localparam logic [4:0] OFF_DST = 5'h0c;
   localparam logic [4:0] OFF_CNT = 5'h10;
   localparam logic [4:0] OFF_ACNT = 5'h14;
   localparam logic [AXI_AW-1:0] OFF_BCT = 8'h80;
   localparam logic [AXI_AW-1:0] OFF_STAT = 8'h84;
   localparam int GLOBAL_BIT = 7;
   localparam int CH_SEL_LSB = 5;

   // Channel control and trigger register fields.
   localparam int CTL_EN = 0;
   localparam int CTL_STG = 1;
   localparam int CTL_INIT = 2;
   localparam int CTL_TC = 3;
   localparam int CTL_MODE_LSB = 4;
   localparam int CTL_HALF = 6;
   localparam int CTL_SOBJ_LSB = 8;
   localparam int CTL_DOBJ_LSB = 10;
   localparam int TRIG_ON = 7;
   localparam int TRIG_SEL_W = 3;

   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_STEP = 2'h1;
   localparam logic [1:0] MODE_BLOCK = 2'h2;

   localparam logic [1:0] OBJ_RAM = 2'h0;
   localparam logic [1:0] OBJ_PERI = 2'h1;
   localparam logic [1:0] OBJ_EXT_IO = 2'h2;
   localparam logic [1:0] OBJ_EXT_MEM = 2'h3;

   // Bus cycle type register: wait clocks for external cycles.
   localparam int BCT_MEM_LSB = 0;
   localparam int BCT_IO_LSB = 4;
   localparam int BCT_W = 4;

   // Minimum clock counts.
   localparam logic [TMR_W-1:0] ACK_LEAD_CLK = 6'h04;
   localparam logic [TMR_W-1:0] RAM_CLK = 6'h02;
   localparam logic [TMR_W-1:0] PERI_CLK = 6'h03;
   localparam logic [TMR_W-1:0] EXT_BASE_CLK = 6'h02;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {FCD_IDLE, FCD_START, FCD_XFER, FCD_END} fcd_state_t;
endpackage

// *** tb/fcd_io_dev.sv ***
// External I/O requester model for the DMA request pins.
`timescale 1ns/1ps
`default_nettype none
module fcd_io_dev (
   input wire logic core_clk,
   input wire logic [3:0] go,
   input wire logic [3:0] ack_n,
   output logic [3:0] req_n
);
   initial req_n = 4'hf;
   // A released pin is pulled up, so it reads as inactive and never as a stale request.
   always @(posedge core_clk) begin
      for (int i = 0; i < 4; i++) begin
         if (!ack_n[i]) begin
            req_n[i] <= 1'b1;
         end else if (go[i]) begin
            req_n[i] <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/fcd_checker.sv ***
// Concurrent checks on the DMA controller pins.
`timescale 1ns/1ps
`default_nettype none
module fcd_checker (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic [3:0] xfer_request_pin_n,
   input wire logic [3:0] xfer_acknowledge_pin_n,
   input wire logic [3:0] terminal_count_n,
   input wire logic [3:0] transfer_end_irq,
   input wire logic xfer_strobe,
   input wire logic bus_hold,
   input wire logic refresh_active
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_tc_one_clk: assert property (!(&terminal_count_n) |=> &terminal_count_n)
      else $error("tc pulse too long");
   a_tc_after_ack: assert property (
      $fell(terminal_count_n[0]) |-> $past(xfer_acknowledge_pin_n[0]))
      else $error("tc without ack gap");
   a_irq_on_tc: assert property ($fell(terminal_count_n[0]) |-> transfer_end_irq[0])
      else $error("no end irq");
   a_ack_lead: assert property (
      $fell(xfer_acknowledge_pin_n[0]) |-> !$past(xfer_request_pin_n[0], 4))
      else $error("ack too early");
   a_one_ack: assert property ($onehot0(~xfer_acknowledge_pin_n))
      else $error("two acks");
   a_strobe_pulse: assert property (xfer_strobe |=> !xfer_strobe)
      else $error("strobe too long");
   a_cycle_min: assert property ($fell(xfer_acknowledge_pin_n[0]) |-> !xfer_strobe [*4])
      else $error("cycle too short");
   a_hold_stall: assert property ((bus_hold || refresh_active) |=> !xfer_strobe)
      else $error("cycle ran in hold");
   c_tc: cover property ($fell(terminal_count_n[0]));
   c_hold: cover property (bus_hold && !xfer_acknowledge_pin_n[0]);
   c_strobe: cover property (xfer_strobe);
endmodule
bind fcd_dma_ctrl fcd_checker fcd_checker_i (.*);
`default_nettype wire

// *** tb/fcd_dma_ctrl_bench.sv ***
// Self-checking bench for the four-channel DMA controller.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
   $display("ERROR %0t got %h exp %h", $time, a, b); end end
module fcd_dma_ctrl_bench;
   logic core_clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, bus_hold = 0, refresh_active = 0, nmi_in = 0;
   logic xfer_strobe, ext_bus_used;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, periph_irq = 0, seed = 8'h3a;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, xfer_src_addr, xfer_dst_addr, rd, s;
   logic [3:0] s_axi_wstrb = 4'hf, xfer_request_pin_n, xfer_acknowledge_pin_n, go = 0;
   logic [3:0] terminal_count_n, transfer_end_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   int n_errors = 0, n_compared = 0, k, n, m;
   fcd_dma_ctrl fcd_dma_ctrl_i (.*);
   fcd_io_dev fcd_io_dev_i (.core_clk(core_clk), .go(go), .ack_n(xfer_acknowledge_pin_n),
      .req_n(xfer_request_pin_n));
   always #2.5 core_clk = ~core_clk;
   function automatic logic [7:0] lfsr(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction
   function automatic logic [31:0] even(input logic [31:0] a);
      return a & 32'hfffffffe;
   endfunction
   always @(posedge core_clk) begin
      seed <= lfsr(seed);
      bus_hold <= seed[2:0] == 3'h0;
      refresh_active <= seed[7:5] == 3'h7;
   end
   task automatic ax(input bit w, input logic [7:0] a, input logic [31:0] d);
      if (w) begin
         s_axi_awaddr <= a; s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
      end
      for (k = 0; k < 50 && !(s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready); k++)
      begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (k == 50) n_errors++;
      rd = s_axi_rdata;
      rs = w ? s_axi_bresp : s_axi_rresp;
      s_axi_bready <= 1'b0; s_axi_rready <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wait_tc(input int ch);
      n = 0;
      for (k = 0; k < 400 && terminal_count_n[ch] !== 1'b0; k++) begin
         @(posedge core_clk);
         n += int'(xfer_strobe);
      end
      `CHK(terminal_count_n[ch], 1'b0)
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (6) @(posedge core_clk);
      `CHK({xfer_acknowledge_pin_n, terminal_count_n, transfer_end_irq}, 12'hff0)
      arst_n <= 1'b1;
      for (int c = 3; c >= 0; c -= 3) begin
         s = {24'h0, seed} | 32'h1;
         ax(1, 8'(c * 32 + 8), s);
         ax(1, 8'(c * 32 + 12), ~s);
         ax(1, 8'(c * 32 + 16), 32'h1);
         ax(1, 8'(c * 32), 32'h41);
      end
      go <= 4'h9;
      @(posedge core_clk);
      go <= 4'h0;
      for (k = 0; k < 100 && &xfer_acknowledge_pin_n; k++) @(posedge core_clk);
      `CHK(xfer_acknowledge_pin_n, 4'he)
      `CHK(xfer_src_addr, even(s))
      `CHK(xfer_dst_addr, even(~s))
      wait_tc(0);
      `CHK(n, 1)
      `CHK(transfer_end_irq[0], 1'b1)
      wait_tc(3);
      `CHK(n, 1)
      ax(0, 8'h00, 32'h0);
      `CHK(rd[3:0], 4'h8)
      ax(1, 8'h30, 32'h2);
      ax(1, 8'h20, 32'h13);
      wait_tc(1);
      `CHK(n, 2)
      s = {29'h0, seed[2:0]};
      ax(1, 8'h44, s | 32'h80);
      ax(1, 8'h50, 32'h1);
      ax(1, 8'h40, 32'h1);
      periph_irq <= 8'h1 << s[2:0];
      @(posedge core_clk);
      periph_irq <= 8'h0;
      wait_tc(2);
      `CHK(n, 1)
      ax(1, 8'h30, 32'h5);
      ax(1, 8'h20, 32'h2b);
      ax(1, 8'h20, 32'h4);
      n = 0;
      for (k = 0; k < 40; k++) begin
         @(posedge core_clk);
         n += int'(!terminal_count_n[1]);
      end
      `CHK(n, 0)
      `CHK(transfer_end_irq[1], 1'b0)
      ax(1, 8'h80, 32'h11);
      ax(1, 8'h50, 32'h3);
      ax(1, 8'h40, 32'h32b);
      nmi_in <= 1'b1;
      m = 0;
      n = 0;
      for (k = 0; k < 40; k++) begin
         @(posedge core_clk);
         nmi_in <= k < 2;
         m += int'(xfer_strobe);
         n += int'(ext_bus_used);
      end
      `CHK(n != 0, 1'b1)
      `CHK(transfer_end_irq[2], 1'b0)
      ax(0, 8'h40, 32'h0);
      `CHK(rd[3:0], 4'h0)
      ax(1, 8'h40, 32'h321);
      wait_tc(2);
      `CHK(n + m, 3)
      ax(0, 8'h88, 32'h0);
      `CHK(rs, 2'h2)
      tally_and_finish;
   end
endmodule
`default_nettype wire
